//--- testbench/i2cs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// Two-wire bus master. It only ever pulls a line low; the pull-ups give the high level,
// so a released line never shows a stale value.
module i2cs_master_model #(
    parameter int HALF = 8
) (
    // Clock
    input wire logic clk,
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Pull-down controls
    output logic scl_low,
    output logic sda_low,
    // Clock stretch wait ran out
    output logic hang
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hang = 1'b0;
    end

    task automatic hw();
        repeat (HALF) @(posedge clk);
    endtask

    // The slave may hold SCL low, so a high phase waits for the wire itself.
    task automatic scl_up();
        int i;
        scl_low <= 1'b0;
        for (i = 0; i < 4000 && scl !== 1'b1; i++)
            @(posedge clk);
        if (scl !== 1'b1)
            hang <= 1'b1;
        hw();
    endtask

    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        hw();
        scl_up();
        s = sda;
        scl_low <= 1'b1;
        hw();
    endtask

    task automatic start();
        sda_low <= 1'b1;
        hw();
        scl_low <= 1'b1;
        hw();
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        hw();
        scl_up();
        sda_low <= 1'b0;
        hw();
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        int i;
        logic s;
        for (i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask

    task automatic rd_byte(input logic ack_bit, output logic [7:0] b);
        int i;
        logic s;
        for (i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(ack_bit, s);
    endtask
endmodule
`default_nettype wire

//--- testbench/test_i2c_slave_xfer_timeout.sv
`timescale 1ns/10ps
`default_nettype none
module test_i2c_slave_xfer_timeout;
    localparam int LDIV = 2;
    // Period select 1 gives two slow ticks.
    localparam int TO = 2 * i2cs_pkg::TICK_PRESCALE * LDIV;
    localparam logic [4:0] A_CSR = i2cs_pkg::OFS_BUS_CTRL_STATUS;
    localparam logic [4:0] A_DAT = i2cs_pkg::OFS_SERIAL_DATA;
    localparam logic [4:0] A_OWN = i2cs_pkg::OFS_OWN_ADDRESS;
    localparam logic [4:0] A_MOD = i2cs_pkg::OFS_SERIAL_MODE_CTRL;
    localparam logic [4:0] A_TOC = i2cs_pkg::OFS_BUS_TIMEOUT_CTRL;
    localparam logic [31:0] F = 32'hffffffff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic scl_oe;
    logic sda_oe;
    logic m_scl_low;
    logic m_sda_low;
    logic hang;
    logic scl_o;
    logic sda_o;
    logic evp;
    int ev_cnt = 0;
    wire scl;
    wire sda;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] rv;
    logic ack;
    logic [7:0] b;

    assign scl = !(m_scl_low | scl_oe);
    assign sda = !(m_sda_low | sda_oe);

    always #2.5 clk = ~clk;

    i2cs_slave #(.LSC_DIV(LDIV)) DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
        .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
        .event_pulse(evp));

    // Each event stands for one cycle, so it is counted once per edge that sees it high.
    always @(posedge clk)
    begin
        if (evp === 1'b1)
            ev_cnt++;
    end

    i2cs_master_model mst (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
        .sda_low(m_sda_low), .hang(hang));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Entered just after a rising edge; one edge passes at the end so that the next
    // access never assigns the strobes twice in one time step.
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
        int i;
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (avs_waitrequest !== 1'b0)
        begin
            errors++;
            print_verdict();
        end
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h00000000);
        check($sformatf("reg_%h", a), rv & m, e);
    endtask

    always @(posedge hang)
    begin
        errors++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(A_CSR, F, 32'h81);
        rc(A_TOC, F, 32'h00);
        rc(A_DAT, F, 32'h00);
        rc(A_OWN, F, 32'h00);
        rc(A_MOD, F, 32'h00);
        acc(1'b1, 5'h14, 32'hff);
        rc(5'h14, F, 32'h00);
        acc(1'b1, A_TOC, 32'h3f);
        rc(A_TOC, F, 32'h3f);
        acc(1'b1, A_MOD, 32'h01);
        acc(1'b1, A_OWN, 32'h5a);
        acc(1'b1, A_TOC, 32'h00);
        $display("test reset_regs done");

        mst.start();
        mst.wr_byte({7'h5a, 1'b0}, ack);
        check("addr_ack", ack, 32'h0);
        rc(A_CSR, 32'h64, 32'h60);
        repeat (20) @(posedge clk);
        check("scl_hold", scl_oe, 32'h1);
        acc(1'b0, A_DAT, 32'h00);
        repeat (3) @(posedge clk);
        check("scl_free", scl_oe, 32'h0);
        mst.wr_byte(8'ha5, ack);
        check("data_ack", ack, 32'h0);
        rc(A_CSR, 32'h80, 32'h80);
        rc(A_DAT, F, 32'ha5);
        acc(1'b1, A_CSR, 32'h08);
        mst.wr_byte(8'h3c, ack);
        check("ack_level", ack, 32'h1);
        rc(A_DAT, F, 32'h3c);
        acc(1'b1, A_CSR, 32'h00);
        mst.stop();
        rc(A_CSR, 32'h60, 32'h00);
        $display("test write_xfer done");

        mst.start();
        mst.wr_byte({7'h22, 1'b0}, ack);
        check("addr_nack", ack, 32'h1);
        rc(A_CSR, 32'h40, 32'h00);
        mst.stop();
        $display("test addr_miss done");

        // Shortest period: a run this long only survives if every SCL fall restarts the time-out base.
        acc(1'b1, A_TOC, 32'h80);
        mst.start();
        mst.wr_byte({7'h5a, 1'b1}, ack);
        check("addr_ack", ack, 32'h0);
        rc(A_CSR, 32'h64, 32'h64);
        acc(1'b1, A_CSR, 32'h10);
        acc(1'b1, A_DAT, 32'hc3);
        mst.rd_byte(1'b0, b);
        check("tx_byte", b, 32'hc3);
        rc(A_CSR, 32'h01, 32'h00);
        acc(1'b1, A_DAT, 32'h81);
        mst.rd_byte(1'b1, b);
        check("tx_byte", b, 32'h81);
        check("sda_free", sda_oe, 32'h0);
        rc(A_CSR, 32'h01, 32'h01);
        mst.stop();
        repeat (150) @(posedge clk);
        rc(A_TOC, F, 32'h80);
        $display("test read_xfer done");

        acc(1'b1, A_CSR, 32'h00);
        acc(1'b1, A_TOC, 32'h81);
        mst.start();
        mst.wr_byte({7'h5a, 1'b0}, ack);
        repeat (TO - 24) @(posedge clk);
        rc(A_TOC, F, 32'h81);
        repeat (30) @(posedge clk);
        rc(A_TOC, F, 32'h41);
        rc(A_CSR, F, 32'h81);
        rc(A_OWN, F, 32'h5a);
        rc(A_MOD, F, 32'h01);
        check("pins_free", {scl_oe, sda_oe}, 32'h0);
        repeat (100) @(posedge clk);
        rc(A_TOC, F, 32'h41);
        acc(1'b1, A_TOC, 32'h00);
        rc(A_TOC, F, 32'h00);
        mst.stop();
        $display("test timeout done");
        // Three events per transfer test, match and time-out in the last one.
        check("events", ev_cnt, 32'h8);
        check("pins_level", {scl_o, sda_o}, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

//--- verilog/i2cs_pkg.sv
`default_nettype none
package i2cs_pkg;
    // Register byte addresses on the 32-bit bus.
    localparam logic [4:0] OFS_BUS_CTRL_STATUS = 5'h00;
    localparam logic [4:0] OFS_SERIAL_DATA = 5'h04;
    localparam logic [4:0] OFS_OWN_ADDRESS = 5'h08;
    localparam logic [4:0] OFS_SERIAL_MODE_CTRL = 5'h0c;
    localparam logic [4:0] OFS_BUS_TIMEOUT_CTRL = 5'h10;

    // Field positions of bus_ctrl_status_reg.
    localparam int CSR_BYTE_DONE = 7;
    localparam int CSR_ADDR_MATCH = 6;
    localparam int CSR_BUS_BUSY = 5;
    localparam int CSR_XMIT_SEL = 4;
    localparam int CSR_ACK_SEND = 3;
    localparam int CSR_DIR_READ = 2;
    localparam int CSR_ACK_RCVD = 0;

    // Field positions of bus_timeout_control and serial_mode_ctrl_reg.
    localparam int TOC_ENABLE = 7;
    localparam int TOC_FLAG = 6;
    localparam int TOC_SEL_MSB = 5;
    localparam int MODE_ENABLE = 0;

    // Reset values.
    localparam logic [7:0] CSR_RESET = 8'h81;
    localparam logic [7:0] TOC_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    localparam logic MODE_EN_RESET = 1'b0;

    // Timing: system clock, low-speed clock and the time-out prescale.
    localparam longint CLK_HZ = 200000000;
    localparam longint LSC_HZ = 32768;
    localparam int LSC_DIV_DEFAULT = int'(CLK_HZ / LSC_HZ);
    localparam int TICK_PRESCALE = 32;
    localparam int BYTE_BITS = 8;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_RX_BITS,
        ST_RX_ACK,
        ST_TX_BITS,
        ST_TX_ACK,
        ST_WAIT_STOP
    } i2cs_state_t;
endpackage
`default_nettype wire

//--- verilog/i2cs_slave.sv
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - Read direction makes slave transmit on SDA
// R2 - Write direction makes slave receive from SDA
// R3 - Matching own address gets an acknowledge
// R4 - Master sends STOP when unacknowledged
// R5 - Software sets transmit select from direction
// R6 - Eight-bit bytes, MSB first, after address ack
// R7 - Receiver acknowledges low after eight bits
// R8 - Receiver drives ack_to_send on ninth clock
// R9 - Unacknowledged transmitter releases SDA
// R10 - Transmitter uses ack_received to continue
// R11 - One data register for both directions
// R12 - SCL held until data write or read
// R13 - Time-out starts at match, clears on fall
// R14 - Elapsed period raises time-out
// R15 - STOP halts time-out counting
// R16 - Overflow stops counter, clears enable, flags
// R17 - Time-out resets control/status, keeps others
// R18 - Time-out flag cleared only by software
// R19 - Period is field plus one slow ticks
// R20 - Enable bit 7, flag 6, period 5:0
// R21 - Seven address bits then direction bit
// R22 - Busy set by START, cleared by STOP
// R23 - Byte-complete low while shifting, high after
// R24 - Time-out releases SDA and SCL
module i2cs_slave #(
    parameter int LSC_DIV = i2cs_pkg::LSC_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Two-wire bus, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Shared serial event request
    output logic event_pulse
);
    if (LSC_DIV < 2 || LSC_DIV > 65535)
    begin : g_bad_div
        $error("LSC_DIV must lie in 2..65535");
    end

    typedef struct packed {
        i2cs_pkg::i2cs_state_t st;
        logic byte_complete_flag;
        logic addr_match_flag;
        logic bus_busy_flag;
        logic transmit_select;
        logic ack_to_send;
        logic dir_read_flag;
        logic ack_received;
        logic [7:0] data;
        logic [6:0] own_addr;
        logic mode_en;
        logic to_en;
        logic to_flag;
        logic [5:0] to_sel;
        logic to_run;
        logic [5:0] to_cnt;
        logic [15:0] lsc_cnt;
        logic [4:0] pre_cnt;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic scl_q;
        logic sda_q;
        logic sda_drv;
        logic scl_drv;
        logic wreq;
        logic [31:0] rdata;
        logic evt;
        logic pin_lvl;
    } i2cs_regs_t;

    i2cs_regs_t r_reg;
    i2cs_regs_t r_next;

    logic take_rd;
    logic take_wr;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic hold_release;
    logic to_tick;
    logic to_ovf;
    logic [7:0] csr_view;
    logic [7:0] toc_view;

    always_comb
    begin
        take_rd = avs_read && !r_reg.wreq;
        take_wr = avs_write && !r_reg.wreq;
        scl_rise = scl_in && !r_reg.scl_q;
        scl_fall = !scl_in && r_reg.scl_q;
        start_ev = r_reg.scl_q && scl_in && r_reg.sda_q && !sda_in;
        stop_ev = r_reg.scl_q && scl_in && !r_reg.sda_q && sda_in;
        // Only the access matching the current direction frees the clock.
        hold_release = (r_reg.st == i2cs_pkg::ST_HOLD) && (avs_address == i2cs_pkg::OFS_SERIAL_DATA)
            && ((take_wr && r_reg.transmit_select) || (take_rd && !r_reg.transmit_select)); // R12
        to_tick = (r_reg.lsc_cnt == 16'(LSC_DIV - 1))
            && (r_reg.pre_cnt == 5'(i2cs_pkg::TICK_PRESCALE - 1));
        to_ovf = r_reg.to_en && r_reg.to_run && to_tick && !scl_fall
            && (r_reg.to_cnt == r_reg.to_sel); // R14 R19
        csr_view = 8'h00;
        csr_view[i2cs_pkg::CSR_BYTE_DONE] = r_reg.byte_complete_flag;
        csr_view[i2cs_pkg::CSR_ADDR_MATCH] = r_reg.addr_match_flag;
        csr_view[i2cs_pkg::CSR_BUS_BUSY] = r_reg.bus_busy_flag;
        csr_view[i2cs_pkg::CSR_XMIT_SEL] = r_reg.transmit_select;
        csr_view[i2cs_pkg::CSR_ACK_SEND] = r_reg.ack_to_send;
        csr_view[i2cs_pkg::CSR_DIR_READ] = r_reg.dir_read_flag;
        csr_view[i2cs_pkg::CSR_ACK_RCVD] = r_reg.ack_received;
        toc_view = {r_reg.to_en, r_reg.to_flag, r_reg.to_sel}; // R20
    end

    always_comb
    begin
        r_next = r_reg;
        r_next.evt = 1'b0;
        r_next.scl_q = scl_in;
        r_next.sda_q = sda_in;

        // Bus slave: one wait cycle, then the access is taken.
        if ((avs_read || avs_write) && r_reg.wreq)
        begin
            r_next.wreq = 1'b0;
            case (avs_address)
                i2cs_pkg::OFS_BUS_CTRL_STATUS: r_next.rdata = {24'h000000, csr_view};
                i2cs_pkg::OFS_SERIAL_DATA: r_next.rdata = {24'h000000, r_reg.data};
                i2cs_pkg::OFS_OWN_ADDRESS: r_next.rdata = {25'h0000000, r_reg.own_addr};
                i2cs_pkg::OFS_SERIAL_MODE_CTRL: r_next.rdata = {31'h00000000, r_reg.mode_en};
                i2cs_pkg::OFS_BUS_TIMEOUT_CTRL: r_next.rdata = {24'h000000, toc_view};
                default: r_next.rdata = 32'h00000000;
            endcase
        end
        else
        begin
            r_next.wreq = 1'b1;
        end

        if (take_wr)
        begin
            case (avs_address)
                i2cs_pkg::OFS_BUS_CTRL_STATUS:
                begin
                    r_next.transmit_select = avs_writedata[i2cs_pkg::CSR_XMIT_SEL]; // R5
                    r_next.ack_to_send = avs_writedata[i2cs_pkg::CSR_ACK_SEND];
                end
                i2cs_pkg::OFS_SERIAL_DATA: r_next.data = avs_writedata[7:0]; // R11
                i2cs_pkg::OFS_OWN_ADDRESS: r_next.own_addr = avs_writedata[6:0];
                i2cs_pkg::OFS_SERIAL_MODE_CTRL: r_next.mode_en = avs_writedata[i2cs_pkg::MODE_ENABLE];
                i2cs_pkg::OFS_BUS_TIMEOUT_CTRL:
                begin
                    r_next.to_en = avs_writedata[i2cs_pkg::TOC_ENABLE];
                    r_next.to_flag = avs_writedata[i2cs_pkg::TOC_FLAG];
                    r_next.to_sel = avs_writedata[i2cs_pkg::TOC_SEL_MSB:0];
                end
                default:
                begin
                    r_next.wreq = 1'b1;
                end
            endcase
        end

        // Time-out base: low-speed clock enable, then divide by 32.
        if (r_reg.lsc_cnt == 16'(LSC_DIV - 1))
        begin
            r_next.lsc_cnt = 16'h0000;
            r_next.pre_cnt = r_reg.pre_cnt + 5'h01;
        end
        else
        begin
            r_next.lsc_cnt = r_reg.lsc_cnt + 16'h0001;
        end
        if (to_tick && r_reg.to_en && r_reg.to_run)
        begin
            r_next.to_cnt = r_reg.to_cnt + 6'h01;
        end
        if (scl_fall)
        begin
            // Restarting the base too keeps the period exact.
            r_next.to_cnt = 6'h00; // R13
            r_next.lsc_cnt = 16'h0000;
            r_next.pre_cnt = 5'h00;
        end

        // Bit engine.
        case (r_reg.st)
            i2cs_pkg::ST_IDLE:
            begin
                r_next.sda_drv = 1'b0;
                r_next.scl_drv = 1'b0;
            end
            i2cs_pkg::ST_ADDR, i2cs_pkg::ST_RX_BITS:
            begin
                if (scl_rise && r_reg.bit_cnt != 4'(i2cs_pkg::BYTE_BITS))
                begin
                    r_next.shift = {r_reg.shift[6:0], sda_in}; // R6 R2
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                end
                if (scl_fall && r_reg.bit_cnt == 4'(i2cs_pkg::BYTE_BITS))
                begin
                    if (r_reg.st == i2cs_pkg::ST_RX_BITS)
                    begin
                        r_next.data = r_reg.shift; // R11
                        r_next.byte_complete_flag = 1'b1; // R23
                        r_next.evt = 1'b1;
                        r_next.sda_drv = !r_reg.ack_to_send; // R7 R8
                        r_next.st = i2cs_pkg::ST_RX_ACK;
                    end
                    else if (r_reg.shift[7:1] == r_reg.own_addr)
                    begin
                        r_next.addr_match_flag = 1'b1; // R21
                        r_next.dir_read_flag = r_reg.shift[0]; // R1 R2
                        r_next.evt = 1'b1;
                        r_next.sda_drv = 1'b1; // R3
                        r_next.to_run = 1'b1; // R13
                        r_next.st = i2cs_pkg::ST_ADDR_ACK;
                    end
                    else
                    begin
                        r_next.st = i2cs_pkg::ST_WAIT_STOP;
                    end
                end
            end
            i2cs_pkg::ST_ADDR_ACK, i2cs_pkg::ST_RX_ACK:
            begin
                if (scl_fall)
                begin
                    r_next.sda_drv = 1'b0;
                    r_next.scl_drv = 1'b1; // R12
                    r_next.st = i2cs_pkg::ST_HOLD;
                end
            end
            i2cs_pkg::ST_HOLD:
            begin
                if (hold_release)
                begin
                    r_next.scl_drv = 1'b0;
                    r_next.bit_cnt = 4'h0;
                    r_next.byte_complete_flag = 1'b0; // R23
                    if (r_reg.transmit_select)
                    begin
                        r_next.shift = avs_writedata[7:0];
                        r_next.sda_drv = !avs_writedata[7]; // R1 R6
                        r_next.st = i2cs_pkg::ST_TX_BITS;
                    end
                    else
                    begin
                        r_next.st = i2cs_pkg::ST_RX_BITS; // R2
                    end
                end
            end
            i2cs_pkg::ST_TX_BITS:
            begin
                if (scl_fall)
                begin
                    if (r_reg.bit_cnt == 4'(i2cs_pkg::BYTE_BITS - 1))
                    begin
                        r_next.sda_drv = 1'b0;
                        r_next.st = i2cs_pkg::ST_TX_ACK;
                    end
                    else
                    begin
                        r_next.shift = {r_reg.shift[6:0], 1'b0}; // R6
                        r_next.sda_drv = !r_reg.shift[6];
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end
                end
            end
            i2cs_pkg::ST_TX_ACK:
            begin
                if (scl_rise)
                begin
                    r_next.ack_received = sda_in; // R7
                end
                if (scl_fall)
                begin
                    r_next.byte_complete_flag = 1'b1; // R23
                    r_next.evt = 1'b1;
                    if (r_reg.ack_received)
                    begin
                        // The master will end the frame with STOP.
                        r_next.st = i2cs_pkg::ST_WAIT_STOP; // R9 R10 R4
                    end
                    else
                    begin
                        r_next.scl_drv = 1'b1; // R10 R12
                        r_next.st = i2cs_pkg::ST_HOLD;
                    end
                end
            end
            i2cs_pkg::ST_WAIT_STOP:
            begin
                r_next.sda_drv = 1'b0; // R9
                r_next.scl_drv = 1'b0;
            end
            default:
            begin
                r_next.st = i2cs_pkg::ST_IDLE;
            end
        endcase

        if (stop_ev)
        begin
            r_next.bus_busy_flag = 1'b0; // R22
            r_next.to_run = 1'b0; // R15
            r_next.addr_match_flag = 1'b0;
            r_next.sda_drv = 1'b0;
            r_next.scl_drv = 1'b0;
            r_next.st = i2cs_pkg::ST_IDLE;
        end
        else if (start_ev)
        begin
            // A repeated START with no time-out in the same cycle restarts address reception from any state while mode_en is set, else returns to ST_IDLE.
            r_next.bus_busy_flag = 1'b1; // R22
            r_next.addr_match_flag = 1'b0;
            r_next.to_run = 1'b0;
            r_next.bit_cnt = 4'h0;
            r_next.sda_drv = 1'b0;
            r_next.scl_drv = 1'b0;
            r_next.st = r_reg.mode_en ? i2cs_pkg::ST_ADDR : i2cs_pkg::ST_IDLE;
        end

        if (to_ovf)
        begin
            r_next.to_run = 1'b0; // R16
            r_next.to_en = 1'b0; // R16
            r_next.to_flag = 1'b1; // R16 R18
            r_next.evt = 1'b1;
            r_next.byte_complete_flag = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_BYTE_DONE]; // R17
            r_next.addr_match_flag = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_ADDR_MATCH];
            r_next.bus_busy_flag = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_BUS_BUSY];
            r_next.transmit_select = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_XMIT_SEL];
            r_next.ack_to_send = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_ACK_SEND];
            r_next.dir_read_flag = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_DIR_READ];
            r_next.ack_received = i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_ACK_RCVD];
            r_next.sda_drv = 1'b0; // R24
            r_next.scl_drv = 1'b0; // R24
            r_next.st = i2cs_pkg::ST_IDLE; // R17
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
            r_reg.st <= i2cs_pkg::ST_IDLE;
            r_reg.byte_complete_flag <= i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_BYTE_DONE];
            r_reg.ack_received <= i2cs_pkg::CSR_RESET[i2cs_pkg::CSR_ACK_RCVD];
            r_reg.data <= i2cs_pkg::DATA_RESET;
            r_reg.own_addr <= i2cs_pkg::OWN_ADDR_RESET;
            r_reg.mode_en <= i2cs_pkg::MODE_EN_RESET;
            r_reg.to_en <= i2cs_pkg::TOC_RESET[i2cs_pkg::TOC_ENABLE];
            r_reg.to_flag <= i2cs_pkg::TOC_RESET[i2cs_pkg::TOC_FLAG];
            r_reg.to_sel <= i2cs_pkg::TOC_RESET[i2cs_pkg::TOC_SEL_MSB:0];
            r_reg.scl_q <= 1'b1;
            r_reg.sda_q <= 1'b1;
            r_reg.wreq <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign avs_readdata = r_reg.rdata;
    assign avs_waitrequest = r_reg.wreq;
    assign scl_out = r_reg.pin_lvl;
    assign sda_out = r_reg.pin_lvl;
    assign scl_oe = r_reg.scl_drv;
    assign sda_oe = r_reg.sda_drv;
    assign event_pulse = r_reg.evt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic addr_hit;
    logic rx_byte_end;
    logic toc_wr;
    assign addr_hit = (r_reg.st == i2cs_pkg::ST_ADDR) && scl_fall && !start_ev && !stop_ev
        && !to_ovf && r_reg.bit_cnt == 4'(i2cs_pkg::BYTE_BITS)
        && r_reg.shift[7:1] == r_reg.own_addr;
    assign rx_byte_end = (r_reg.st == i2cs_pkg::ST_RX_BITS) && scl_fall && !start_ev
        && !stop_ev && !to_ovf && r_reg.bit_cnt == 4'(i2cs_pkg::BYTE_BITS);
    assign toc_wr = take_wr && avs_address == i2cs_pkg::OFS_BUS_TIMEOUT_CTRL;

    sequence match_seen_s;
        addr_hit ##0 (r_reg.shift[0] == r_reg.shift[0]);
    endsequence
    sequence ack_driven_s;
        r_reg.sda_drv && r_reg.addr_match_flag && r_reg.st == i2cs_pkg::ST_ADDR_ACK;
    endsequence

    addr_ack_a: assert property (match_seen_s |=> ack_driven_s) // R3
        else $error("matched address not acknowledged");
    dir_capture_a: assert property (addr_hit |=> r_reg.dir_read_flag == $past(r_reg.shift[0])) // R21
        else $error("direction bit not captured");
    busy_start_a: assert property (start_ev && !to_ovf |=> r_reg.bus_busy_flag) // R22
        else $error("busy not set on START");
    busy_stop_a: assert property (stop_ev |=> !r_reg.bus_busy_flag && !r_reg.to_run) // R15
        else $error("STOP did not clear busy or time-out run");
    to_fire_a: assert property (to_ovf |=> r_reg.to_flag && !r_reg.to_en && !r_reg.to_run
        && r_reg.byte_complete_flag && r_reg.ack_received && !r_reg.bus_busy_flag && !r_reg.sda_drv && !r_reg.scl_drv) // R16
        else $error("time-out did not reset state");
    flag_sticky_a: assert property (r_reg.to_flag && !toc_wr |=> r_reg.to_flag) // R18
        else $error("time-out flag lost without software");
    scl_hold_a: assert property (r_reg.st == i2cs_pkg::ST_HOLD && !hold_release
        && !start_ev && !stop_ev && !to_ovf |=> r_reg.scl_drv) // R12
        else $error("clock released without service");
    to_clear_a: assert property (scl_fall |=> r_reg.to_cnt == 6'h00) // R13
        else $error("time-out count not cleared on SCL fall");
    rx_ack_a: assert property (rx_byte_end |=> r_reg.sda_drv == !$past(r_reg.ack_to_send)
        && r_reg.byte_complete_flag) // R8
        else $error("ninth-clock acknowledge wrong");
    tx_msb_a: assert property (hold_release && r_reg.transmit_select && !start_ev && !stop_ev && !to_ovf
        |=> r_reg.sda_drv == !$past(avs_writedata[7]) ##1 !r_reg.byte_complete_flag [*1]) // R6
        else $error("first transmitted bit is not MSB");
endmodule
`default_nettype wire
